// file: alu_ops_pkg.sv
// Constants, register map and types for the magnitude and sum ALU slice.
//
// Summary of operation
// - Plain magnitude writes source or zero minus source.
// - Plain magnitude: carry is source MSB, zero on result.
// - Plain magnitude: negative and overflow flag most-negative source.
// - Flags change only when flag-update bit is set.
// - Saturating magnitude clamps most-negative source to maximum.
// - Saturating forms: zero, negative from source; carry kept.
// - Saturating forms: overflow equals this saturation.
// - Sticky saturation flag ORs in each saturation.
// - Saturation sets both saturation bits together.
// - Halfword form: low half magnitude, clamps to 0x7FFF.
// - Add-with-carry writes first plus second plus carry.
// - Add writes first plus second operand.
// - Add forms set zero, negative, carry-out, signed overflow.
// - Saturation bits live in the auxiliary mode register.
package alu_ops_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_SRC1 = 8'h00;
   localparam logic [7:0] OFF_SRC2 = 8'h04;
   localparam logic [7:0] OFF_CMD = 8'h08;
   localparam logic [7:0] OFF_RESULT = 8'h0C;
   localparam logic [7:0] OFF_FLAGS = 8'h10;
   localparam logic [7:0] OFF_AUX = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h1C;
   localparam logic [7:0] OFF_IRQ_EN = 8'h20;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CMD_SETF = 4;
   localparam int CMD_COND = 5;
   localparam int FLG_Z = 0;
   localparam int FLG_N = 1;
   localparam int FLG_C = 2;
   localparam int FLG_V = 3;
   localparam int AUX_STICKY = 0;
   localparam int AUX_SAT1 = 1;
   localparam int AUX_SAT2 = 2;
   localparam int EV_DONE = 0;
   localparam int EV_SAT = 1;
   localparam int EV_SKIP = 2;

   // ---------------------------------------------------------------
   // Values
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [3:0] RST_FLAGS = 4'h0;
   localparam logic [2:0] RST_AUX = 3'h0;
   localparam logic [2:0] RST_EV = 3'h0;
   localparam logic [31:0] MOST_NEG32 = 32'h8000_0000;
   localparam logic [31:0] MAX_POS32 = 32'h7FFF_FFFF;
   localparam logic [15:0] MOST_NEG16 = 16'h8000;
   localparam logic [31:0] MAX_POS16 = 32'h0000_7FFF;

   typedef enum logic [2:0] {
      OP_MAGNITUDE = 3'h0,
      OP_SATURATING_MAGNITUDE = 3'h1,
      OP_HALFWORD_SATURATING_MAGNITUDE = 3'h2,
      OP_ADD = 3'h3,
      OP_ADD_CARRY = 3'h4
   } op_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_RDWAIT = 2'b10
   } bus_state_t;

endpackage : alu_ops_pkg

// file: bus_master_model.sv
// Bus master model standing in for the decode stage that drives the slice.
module bus_master_model (
   input wire logic clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // ---------------------------------------------------------------
   // Single word transfers
   // ---------------------------------------------------------------
   task automatic addr_phase(input logic [7:0] off, input logic wr);
      @(posedge clk);
      hsel <= 1'h1;
      haddr <= {24'h00_0000, off};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge clk);
      while (hready !== 1'h1) @(posedge clk);
      htrans <= 2'h0;
   endtask : addr_phase

   task automatic write_word(input logic [7:0] off, input logic [31:0] data);
      addr_phase(off, 1'h1);
      hwdata <= data;
      @(posedge clk);
      while (hready !== 1'h1) @(posedge clk);
      // A released data bus must not look like a still valid word.
      hwdata <= ~data;
   endtask : write_word

   task automatic read_word(input logic [7:0] off, output logic [31:0] data);
      addr_phase(off, 1'h0);
      @(posedge clk);
      while (hready !== 1'h1) @(posedge clk);
      data = hrdata;
   endtask : read_word
endmodule : bus_master_model

// file: magnitude_and_sum_alu.sv
// AHB-Lite register front end and datapath of the magnitude and sum ALU slice.
module magnitude_and_sum_alu
   import alu_ops_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq
);

   // ---------------------------------------------------------------
   // Bus front end
   // ---------------------------------------------------------------
   function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : regHit

   logic addrPhase;
   logic wrPend_q;
   logic [7:0] wrAddr_q;
   logic [7:0] rdAddr_q;
   bus_state_t busState_q;
   logic hreadyout_q;
   logic [31:0] hrdata_q;
   logic hresp_q;

   logic [31:0] src1_q;
   logic [31:0] src2_q;
   logic [31:0] result_q;
   logic [3:0] flags_q;
   logic [2:0] aux_q;
   logic [2:0] irqStat_q;
   logic [2:0] irqEn_q;
   logic irq_q;

   assign addrPhase = hsel & htrans[1] & hready;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
      end else begin
         wrPend_q <= addrPhase & hwrite;
         if (addrPhase) begin
            wrAddr_q <= haddr[7:0];
         end
      end
   end

   // Reads take one wait state so that a write in the preceding data
   // phase has landed before the read value is sampled.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busState_q <= BUS_IDLE;
         hreadyout_q <= 1'b1;
         rdAddr_q <= 8'h00;
         hrdata_q <= RST_WORD;
         hresp_q <= 1'b0;
      end else begin
         hresp_q <= 1'b0;
         unique case (busState_q)
            BUS_IDLE: begin
               if (addrPhase && !hwrite) begin
                  busState_q <= BUS_RDWAIT;
                  hreadyout_q <= 1'b0;
                  rdAddr_q <= haddr[7:0];
               end
            end
            BUS_RDWAIT: begin
               busState_q <= BUS_IDLE;
               hreadyout_q <= 1'b1;
               hrdata_q <= readMux(rdAddr_q);
            end
            default: begin
               busState_q <= BUS_IDLE;
               hreadyout_q <= 1'b1;
            end
         endcase
      end
   end

   function automatic logic [31:0] readMux(input logic [7:0] a);
      logic [31:0] v;
      v = RST_WORD;
      if (regHit(a, OFF_SRC1)) v = src1_q;
      if (regHit(a, OFF_SRC2)) v = src2_q;
      if (regHit(a, OFF_RESULT)) v = result_q;
      if (regHit(a, OFF_FLAGS)) v = {28'h000_0000, flags_q};
      if (regHit(a, OFF_AUX)) v = {29'h0000_0000, aux_q};
      if (regHit(a, OFF_IRQ_STAT)) v = {29'h0000_0000, irqStat_q};
      if (regHit(a, OFF_IRQ_EN)) v = {29'h0000_0000, irqEn_q};
      return v;
   endfunction : readMux

   assign hreadyout = hreadyout_q;
   assign hrdata = hrdata_q;
   assign hresp = hresp_q;
   assign irq = irq_q;

   // ---------------------------------------------------------------
   // Command decode and datapath
   // ---------------------------------------------------------------
   logic execGo;
   logic setF;
   logic condOk;
   logic [2:0] opSel;
   logic isAdd;
   logic isSat;
   logic srcMsb;
   logic srcMostNeg;
   logic halfMostNeg;
   logic [32:0] sum;
   logic [31:0] resD;
   logic wrRes;
   logic [3:0] flagsD;
   logic satNow;
   logic auxWr;

   assign execGo = wrPend_q & regHit(wrAddr_q, OFF_CMD);
   assign opSel = hwdata[2:0];
   assign setF = hwdata[CMD_SETF];
   assign condOk = hwdata[CMD_COND];
   assign isAdd = (opSel == OP_ADD) || (opSel == OP_ADD_CARRY);
   assign isSat = (opSel == OP_SATURATING_MAGNITUDE) ||
                  (opSel == OP_HALFWORD_SATURATING_MAGNITUDE);
   assign srcMsb = src1_q[31];
   assign srcMostNeg = src1_q == MOST_NEG32;
   assign halfMostNeg = src1_q[15:0] == MOST_NEG16;
   assign auxWr = wrPend_q & regHit(wrAddr_q, OFF_AUX);

   always_comb begin
      sum = {1'b0, src1_q} + {1'b0, src2_q};
      if (opSel == OP_ADD_CARRY) begin
         sum = sum + {32'h0000_0000, flags_q[FLG_C]};
      end
      resD = result_q;
      wrRes = 1'b0;
      flagsD = flags_q;
      satNow = 1'b0;
      case (opSel)
         OP_MAGNITUDE: begin
            resD = srcMsb ? 32'h0000_0000 - src1_q : src1_q;
            wrRes = 1'b1;
            flagsD[FLG_Z] = resD == 32'h0000_0000;
            flagsD[FLG_C] = srcMsb;
            flagsD[FLG_N] = srcMostNeg;
            flagsD[FLG_V] = srcMostNeg;
         end
         OP_SATURATING_MAGNITUDE: begin
            satNow = srcMostNeg;
            resD = srcMsb ? 32'h0000_0000 - src1_q : src1_q;
            if (satNow) resD = MAX_POS32;
            wrRes = 1'b1;
         end
         OP_HALFWORD_SATURATING_MAGNITUDE: begin
            satNow = halfMostNeg;
            resD = {16'h0000, src1_q[15] ? 16'h0000 - src1_q[15:0]
                                         : src1_q[15:0]};
            if (satNow) resD = MAX_POS16;
            wrRes = 1'b1;
         end
         OP_ADD, OP_ADD_CARRY: begin
            if (condOk) begin
               resD = sum[31:0];
               wrRes = 1'b1;
               flagsD[FLG_Z] = resD == 32'h0000_0000;
               flagsD[FLG_N] = resD[31];
               flagsD[FLG_C] = sum[32];
               flagsD[FLG_V] = (src1_q[31] == src2_q[31]) &&
                               (resD[31] != src1_q[31]);
            end
         end
         default: begin
            wrRes = 1'b0;
         end
      endcase
      if (isSat) begin
         // Both saturating forms judge the input, not the output.
         flagsD[FLG_Z] = src1_q == 32'h0000_0000;
         flagsD[FLG_N] = srcMsb;
         flagsD[FLG_V] = satNow;
      end
   end

   // ---------------------------------------------------------------
   // Operand, result and flag registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src1_q <= RST_WORD;
         src2_q <= RST_WORD;
      end else if (wrPend_q) begin
         if (regHit(wrAddr_q, OFF_SRC1)) src1_q <= hwdata;
         if (regHit(wrAddr_q, OFF_SRC2)) src2_q <= hwdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_q <= RST_WORD;
      end else if (execGo && wrRes) begin
         result_q <= resD;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= RST_FLAGS;
      end else if (execGo && setF && wrRes) begin
         flags_q <= flagsD;
      end else if (wrPend_q && regHit(wrAddr_q, OFF_FLAGS)) begin
         flags_q <= hwdata[3:0];
      end
   end

   // Only software clears the saturation bits; hardware only sets them.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_q <= RST_AUX;
      end else if (execGo && setF && satNow) begin
         aux_q[AUX_STICKY] <= aux_q[AUX_STICKY] | satNow;
         aux_q[AUX_SAT1] <= 1'b1;
         aux_q[AUX_SAT2] <= 1'b1;
      end else if (auxWr) begin
         aux_q <= hwdata[2:0];
      end
   end

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   logic [2:0] evNow;
   logic [2:0] irqClr;
   logic [2:0] irqStat_d;

   always_comb begin
      evNow = RST_EV;
      evNow[EV_DONE] = execGo & wrRes;
      evNow[EV_SAT] = execGo & satNow;
      evNow[EV_SKIP] = execGo & isAdd & ~condOk;
      irqClr = RST_EV;
      if (wrPend_q && regHit(wrAddr_q, OFF_IRQ_CLR)) irqClr = hwdata[2:0];
      // A new event beats a clear arriving in the same cycle.
      irqStat_d = (irqStat_q & ~irqClr) | evNow;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStat_q <= RST_EV;
         irqEn_q <= RST_EV;
         irq_q <= 1'b0;
      end else begin
         irqStat_q <= irqStat_d;
         if (wrPend_q && regHit(wrAddr_q, OFF_IRQ_EN)) irqEn_q <= hwdata[2:0];
         irq_q <= |(irqStat_d & irqEn_q);
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_abs_value: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && opSel == OP_MAGNITUDE && srcMsb)
      |=> result_q == 32'h0000_0000 - $past(src1_q))
      else $error("magnitude result is not the negated source");

   a_abs_carry: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && opSel == OP_MAGNITUDE && setF)
      |=> flags_q[FLG_C] == $past(srcMsb))
      else $error("magnitude carry does not follow source sign");

   a_abs_negovf: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && opSel == OP_MAGNITUDE && setF)
      |=> flags_q[FLG_N] == $past(srcMostNeg) && flags_q[FLG_V] == flags_q[FLG_N])
      else $error("magnitude negative or overflow flag wrong");

   a_flags_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && !setF) |=> $stable(flags_q) && $stable(aux_q))
      else $error("flags changed without flag-update bit");

   a_sat_clamp: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && opSel == OP_SATURATING_MAGNITUDE && srcMostNeg)
      |=> result_q == MAX_POS32)
      else $error("saturating magnitude did not clamp");

   a_sat_carry: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && isSat && setF) |=> $stable(flags_q[FLG_C])
      && flags_q[FLG_N] == $past(srcMsb))
      else $error("saturating form disturbed carry or negative");

   a_sat_ovf: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && isSat && setF) |=> flags_q[FLG_V] == $past(satNow))
      else $error("overflow does not equal saturation");

   a_sticky_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (aux_q[AUX_STICKY] && !auxWr) |=> aux_q[AUX_STICKY])
      else $error("sticky saturation dropped by hardware");

   a_sat_pair: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && satNow && setF) |=> aux_q[AUX_SAT1] && aux_q[AUX_SAT2] && aux_q[AUX_STICKY])
      else $error("saturation bits not set together");

   a_half_clamp: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && opSel == OP_HALFWORD_SATURATING_MAGNITUDE)
      |=> result_q[31:16] == 16'h0000 && (!$past(halfMostNeg) || result_q == MAX_POS16))
      else $error("halfword magnitude not clamped or extended");

   a_add_skip: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && isAdd && !condOk) |=> $stable(result_q) && $stable(flags_q))
      else $error("failed condition still changed state");

   a_add_sum: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && opSel == OP_ADD && condOk)
      |=> result_q == $past(src1_q) + $past(src2_q))
      else $error("add result is not the operand sum");

   a_carry_sum: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && opSel == OP_ADD_CARRY && condOk)
      |=> result_q == $past(src1_q) + $past(src2_q) + {31'h0000_0000, $past(flags_q[FLG_C])})
      else $error("add with carry result is wrong");

   a_add_flags: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && isAdd && condOk && setF)
      |=> flags_q[FLG_Z] == (result_q == 32'h0000_0000) && flags_q[FLG_N] == result_q[31]
      && flags_q[FLG_V] == ($past(src1_q[31]) == $past(src2_q[31])
      && result_q[31] != $past(src1_q[31])))
      else $error("add zero, negative or overflow flag wrong");

   // A wrapped sum is below the first operand, or equal to it when a carry came in.
   a_add_carry: assert property (@(posedge clk) disable iff (!rst_n)
      (execGo && isAdd && condOk && setF)
      |=> flags_q[FLG_C] == (result_q < $past(src1_q) || ($past(opSel == OP_ADD_CARRY)
      && $past(flags_q[FLG_C]) && result_q == $past(src1_q))))
      else $error("add carry flag is not the carry out");

   a_aux_readback: assert property (@(posedge clk) disable iff (!rst_n)
      (busState_q == BUS_RDWAIT && regHit(rdAddr_q, OFF_AUX))
      |=> hrdata == {29'h0000_0000, $past(aux_q)})
      else $error("saturation bits not readable in the mode register");

   a_read_wait: assert property (@(posedge clk) disable iff (!rst_n)
      (addrPhase && !hwrite && busState_q == BUS_IDLE) |=> !hreadyout ##1 hreadyout)
      else $error("read wait state is not exactly one cycle");

   a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 irq == |($past(irqStat_d) & $past(irqEn_q)))
      else $error("interrupt output disagrees with status");

endmodule : magnitude_and_sum_alu

// file: tb_top.sv
// Self-checking testbench of the magnitude and sum ALU slice.
module tb_top
   import alu_ops_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic rst_n;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic irq;
   int failures;
   int total_checks;
   logic [31:0] expRes;
   logic [3:0] expFlg;
   logic [2:0] expAux;
   logic [2:0] expStat;
   logic [2:0] expEn;
   logic [31:0] rdVal;
   logic [31:0] vecA [6];
   logic [31:0] vecB [6];

   magnitude_and_sum_alu dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

   bus_master_model bm_u (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   // ---------------------------------------------------------------
   // Checking and bus helpers
   // ---------------------------------------------------------------
   task automatic check_value(input string name, input logic [31:0] seen,
                              input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check_value

   task automatic complete_run();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   task automatic wr(input logic [7:0] off, input logic [31:0] data);
      bm_u.write_word(off, data);
   endtask : wr

   task automatic rd_check(input string name, input logic [7:0] off, input logic [31:0] exp);
      bm_u.read_word(off, rdVal);
      check_value(name, rdVal, exp);
      check_value("hresp", {31'h0, hresp}, 32'h0);
   endtask : rd_check

   // One command with freshly preset flags and cleared status, then every visible effect.
   task automatic run_op(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b,
                         input logic setf, input logic cond, input logic [3:0] pf);
      logic [32:0] s;
      logic sat;
      logic [15:0] h;
      wr(OFF_FLAGS, {28'h0, pf});
      wr(OFF_IRQ_CLR, 32'h7);
      wr(OFF_SRC1, a);
      wr(OFF_SRC2, b);
      wr(OFF_CMD, {26'h0, cond, setf, 1'h0, op});
      expFlg = pf;
      expStat = 3'h0;
      h = a[15:0];
      case (op)
         3'h0: begin
            expRes = a[31] ? 32'h0 - a : a;
            expStat[EV_DONE] = 1'h1;
            if (setf) expFlg = {a == MOST_NEG32, a[31], a == MOST_NEG32, expRes == 32'h0};
         end
         3'h1, 3'h2: begin
            sat = (op == 3'h1) ? a == MOST_NEG32 : h == MOST_NEG16;
            if (op == 3'h1) expRes = sat ? MAX_POS32 : (a[31] ? 32'h0 - a : a);
            else expRes = sat ? MAX_POS16 : {16'h0, h[15] ? 16'h0 - h : h};
            expStat[EV_DONE] = 1'h1;
            expStat[EV_SAT] = sat;
            if (setf) expFlg = {sat, pf[2], a[31], a == 32'h0};
            if (setf && sat) expAux = 3'h7;
         end
         3'h3, 3'h4: begin
            if (cond) begin
               s = {1'h0, a} + {1'h0, b} + {32'h0, op == 3'h4 && pf[2]};
               expRes = s[31:0];
               expStat[EV_DONE] = 1'h1;
               if (setf) expFlg = {a[31] == b[31] && s[31] != a[31], s[32], s[31], s[31:0] == 32'h0};
            end else begin
               expStat[EV_SKIP] = 1'h1;
            end
         end
         default: ;
      endcase
      rd_check("result", OFF_RESULT, expRes);
      rd_check("flags", OFF_FLAGS, {28'h0, expFlg});
      rd_check("aux", OFF_AUX, {29'h0, expAux});
      rd_check("status", OFF_IRQ_STAT, {29'h0, expStat});
      check_value("irq", {31'h0, irq}, {31'h0, |(expStat & expEn)});
   endtask : run_op

   // ---------------------------------------------------------------
   // Clock, timeout and main sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      complete_run();
   end

   initial begin
      failures = 0;
      total_checks = 0;
      expRes = 32'h0;
      expFlg = 4'h0;
      expAux = 3'h0;
      expEn = 3'h7;
      vecA = '{32'h0, MOST_NEG32, 32'hFFFF_8000, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 32'h1234_5678};
      vecB = '{32'h0, MOST_NEG32, 32'h0000_8000, 32'h1, 32'h1, 32'hEDCB_A988};
      rst_n = 1'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      rd_check("reset result", OFF_RESULT, 32'h0);
      rd_check("reset flags", OFF_FLAGS, 32'h0);
      rd_check("reset aux", OFF_AUX, 32'h0);
      rd_check("reset enable", OFF_IRQ_EN, 32'h0);
      check_value("reset irq", {31'h0, irq}, 32'h0);
      wr(OFF_IRQ_EN, 32'h7);
      // Aux is cleared once per opcode so later vectors show whether saturation sticks.
      for (int op = 0; op < 8; op++) begin
         wr(OFF_AUX, 32'h0);
         expAux = 3'h0;
         for (int v = 0; v < 6; v++) begin
            for (int k = 0; k < 8; k++) begin
               run_op(op[2:0], vecA[v], vecB[v], k[0], k[1], k[2] ? 4'hF : 4'h0);
            end
         end
      end
      wr(OFF_RESULT, 32'hDEAD_BEEF);
      rd_check("result write", OFF_RESULT, expRes);
      wr(8'h40, 32'h1234_5678);
      rd_check("unmapped", 8'h40, 32'h0);
      rd_check("clear reg", OFF_IRQ_CLR, 32'h0);
      wr(OFF_SRC1, 32'hA5A5_5A5A);
      rd_check("src1", OFF_SRC1, 32'hA5A5_5A5A);
      expEn = 3'h2;
      wr(OFF_IRQ_EN, 32'h2);
      run_op(3'h1, MOST_NEG32, 32'h0, 1'h0, 1'h0, 4'h0);
      expEn = 3'h4;
      wr(OFF_IRQ_EN, 32'h4);
      run_op(3'h1, MOST_NEG32, 32'h0, 1'h1, 1'h0, 4'h0);
      run_op(3'h3, 32'h1, 32'h1, 1'h1, 1'h0, 4'h0);
      complete_run();
   end
endmodule : tb_top
